// File: piezo_pwm_regs.svh
`ifndef PIEZO_PWM_REGS_SVH
`define PIEZO_PWM_REGS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS     40
`define PWM_PERIOD_NS     2000
`define PWM_PERIOD_CYC    (`PWM_PERIOD_NS / `CLK_PERIOD_NS)
`define DUTY_STEP_PCT     5
`define DUTY_STEPS        (100 / `DUTY_STEP_PCT)
`define TABLE_DEPTH       128
`define TABLE_LAST        7'h7F
`define SINGLE_PULSE_TRIGGER_NS        1000000
`define SINGLE_PULSE_TRIGGER_CYC       (`SINGLE_PULSE_TRIGGER_NS / `CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_TBL_PTR       8'h08
`define REG_TBL_DATA      8'h0C
`define REG_VOLT          8'h10
`define REG_GAP           8'h14
`define REG_SOL_CURRENT   8'h18
`define REG_SOL_TIMES     8'h1C
`define REG_CMD           8'h20

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define CTRL_WIDTH        13
`define CTRL_RESET        13'h0A00
`define CMD_CALIBRATE     0
`define CMD_FAULT_CLEAR   1
`define CMD_SINGLE_PULSE  2
`define PTR_TABLE_MSB     8
`define PTR_TABLE_LSB     7
`define DISCHARGE_TABLE   2'h3

`endif

// File: piezo_pwm_pkg.sv
package piezo_pwm_pkg;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_CHARGE,
    SEQ_HOLD,
    SEQ_DISCHARGE
  } seq_e;

  typedef struct packed {
    logic [1:0] charge_table_select;
    logic [1:0] charge_table_count;
    logic       capacitive_mode_select;
    logic       engine_sync_gate;
    logic       single_pulse_mode;
    logic       third_channel_fuel_gate;
    logic       second_channel_fuel_gate;
    logic       first_channel_fuel_gate;
    logic       injection_gate;
    logic       boost_supply_on;
    logic       whole_unit_on;
  } ctrl_s;

  typedef struct packed {
    logic [15:0] firing_voltage_target;
    logic [15:0] idle_voltage_target;
  } volt_s;

  typedef struct packed {
    logic [7:0] solenoid_top_duration;
    logic [7:0] solenoid_reverse_boost_duration;
    logic [7:0] solenoid_hv_top_duration;
    logic [7:0] solenoid_sustain_current;
    logic [7:0] solenoid_top_current;
  } sol_s;

endpackage

// File: pwm_period_gen.sv
`timescale 1ns/10ps
`include "piezo_pwm_regs.svh"

module pwm_period_gen (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Period timing
  output logic [5:0]      phase,
  output logic            period_end
);

  assign period_end = (phase == 6'(`PWM_PERIOD_CYC - 1));

  // Free running so every channel shares one period grid
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase <= 6'h00;
    end else if (period_end) begin
      phase <= 6'h00;
    end else begin
      phase <= phase + 6'h01;
    end
  end

endmodule

// File: piezo_profile_pwm_driver.sv
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`include "piezo_pwm_regs.svh"

module piezo_profile_pwm_driver #(
  parameter int SINGLE_PULSE_TRIGGER_CYCLES = `SINGLE_PULSE_TRIGGER_CYC
) (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // Register port
  input  wire logic [7:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_write,
  input  wire logic                  reg_read,
  output logic [31:0]                reg_rdata,
  // Injection timing, one request per channel
  input  wire logic [2:0]            inject_request,
  // Power switches
  output logic [2:0]                 chan_switch,
  // Solenoid path
  output logic [2:0]                 fire_req,
  output piezo_pwm_pkg::sol_s        sol_cfg,
  // Shared controls
  output piezo_pwm_pkg::ctrl_s       ctrl_out,
  output piezo_pwm_pkg::volt_s       volt_out,
  output logic [15:0]                inter_pulse_gap,
  output logic                       calibration_request,
  output logic                       fault_flags_clear
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  piezo_pwm_pkg::ctrl_s  ctrl_q;
  piezo_pwm_pkg::volt_s  volt_q;
  piezo_pwm_pkg::sol_s   sol_q;
  logic [15:0]           gap_q;
  logic [1:0]            ptr_tbl_q;
  logic [6:0]            ptr_idx_q;
  logic [4:0]            tbl_q [4][`TABLE_DEPTH];
  logic [31:0]           rdata_q;
  logic                  cal_q;
  logic                  clr_q;
  logic [31:0]           single_pulse_trigger_q;
  logic                  shot_load;
  logic [5:0]            phase;
  logic                  period_end;
  logic [1:0]            sel_eff;
  logic [2:0]            req;
  logic [2:0]            fire;
  logic [1:0]            charge_sw;
  logic [1:0]            dis_sw;
  logic [3:0]            st_code;
  logic [13:0]           idx_code;
  logic [2:0]            chan_switch_q;
  logic [4:0]            wr_duty;

  wire wr_ctrl = reg_write && (reg_addr == `REG_CTRL);
  wire wr_data = reg_write && (reg_addr == `REG_TBL_DATA);
  wire wr_cmd  = reg_write && (reg_addr == `REG_CMD);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_q <= piezo_pwm_pkg::ctrl_s'(`CTRL_RESET);
    end else if (wr_ctrl) begin
      ctrl_q <= piezo_pwm_pkg::ctrl_s'(reg_wdata[`CTRL_WIDTH-1:0]);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      volt_q <= '0;
      gap_q  <= 16'h0000;
      sol_q  <= '0;
    end else if (reg_write) begin
      if (reg_addr == `REG_VOLT) volt_q <= piezo_pwm_pkg::volt_s'(reg_wdata);
      if (reg_addr == `REG_GAP) gap_q <= reg_wdata[15:0];
      if (reg_addr == `REG_SOL_CURRENT) sol_q[15:0] <= reg_wdata[15:0];
      if (reg_addr == `REG_SOL_TIMES) sol_q[39:16] <= reg_wdata[23:0];
    end
  end

  // Entries above 100 percent saturate rather than wrap
  assign wr_duty = (reg_wdata[4:0] > 5'(`DUTY_STEPS)) ? 5'(`DUTY_STEPS) : reg_wdata[4:0];

  // Pointer auto-advances so a table loads as 128 back-to-back writes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ptr_tbl_q <= 2'h0;
      ptr_idx_q <= 7'h00;
    end else if (reg_write && (reg_addr == `REG_TBL_PTR)) begin
      ptr_tbl_q <= reg_wdata[`PTR_TABLE_MSB:`PTR_TABLE_LSB];
      ptr_idx_q <= reg_wdata[6:0];
    end else if (wr_data) begin
      ptr_idx_q <= ptr_idx_q + 7'h01;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int t = 0; t < 4; t++) begin
        for (int e = 0; e < `TABLE_DEPTH; e++) begin
          tbl_q[t][e] <= 5'h00;
        end
      end
    end else if (wr_data) begin
      tbl_q[ptr_tbl_q][ptr_idx_q] <= wr_duty;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cal_q <= 1'b0;
      clr_q <= 1'b0;
    end else begin
      cal_q <= wr_cmd && reg_wdata[`CMD_CALIBRATE];
      clr_q <= wr_cmd && reg_wdata[`CMD_FAULT_CLEAR];
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_read) begin
      case (reg_addr)
        `REG_CTRL:        rdata_q <= 32'(ctrl_q);
        `REG_STATUS:      rdata_q <= {12'h000, sel_eff, st_code, idx_code};
        `REG_TBL_PTR:     rdata_q <= {23'h000000, ptr_tbl_q, ptr_idx_q};
        `REG_TBL_DATA:    rdata_q <= {27'h0000000, tbl_q[ptr_tbl_q][ptr_idx_q]};
        `REG_VOLT:        rdata_q <= 32'(volt_q);
        `REG_GAP:         rdata_q <= {16'h0000, gap_q};
        `REG_SOL_CURRENT: rdata_q <= {16'h0000, sol_q[15:0]};
        `REG_SOL_TIMES:   rdata_q <= {8'h00, sol_q[39:16]};
        default:          rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Single pulse and firing gates
  // ----------------------------------------------------------------
  assign shot_load = wr_cmd && reg_wdata[`CMD_SINGLE_PULSE] && ctrl_q.single_pulse_mode;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      single_pulse_trigger_q <= 32'h0000_0000;
    end else if (shot_load) begin
      single_pulse_trigger_q <= 32'(SINGLE_PULSE_TRIGGER_CYCLES);
    end else if (single_pulse_trigger_q != 32'h0000_0000) begin
      single_pulse_trigger_q <= single_pulse_trigger_q - 32'h0000_0001;
    end
  end

  // Single pulse mode masks the timing inputs so a stray request cannot fire
  assign req = ctrl_q.single_pulse_mode ? {2'b00, single_pulse_trigger_q != 32'h0000_0000} : inject_request;
  assign fire = req & {3{ctrl_q.whole_unit_on && ctrl_q.injection_gate}}
              & {ctrl_q.third_channel_fuel_gate, ctrl_q.second_channel_fuel_gate,
                 ctrl_q.first_channel_fuel_gate};

  // Count 0 is treated as one table; a select past the enabled count falls back to table 1
  always_comb begin
    sel_eff = 2'h0;
    if ((ctrl_q.charge_table_select != 2'h0)
        && (ctrl_q.charge_table_select <= ctrl_q.charge_table_count)) begin
      sel_eff = ctrl_q.charge_table_select - 2'h1;
    end
  end

  pwm_period_gen period_gen (
    .clock      (clock),
    .rst        (rst),
    .phase      (phase),
    .period_end (period_end)
  );

  // ----------------------------------------------------------------
  // Per-channel profile sequencers
  // ----------------------------------------------------------------
  for (genvar ch = 0; ch < 2; ch++) begin : chan_g
    piezo_pwm_pkg::seq_e st_q;
    logic [6:0]          idx_q;
    logic [4:0]          duty;
    logic                on;
    wire                 go = fire[ch] && ctrl_q.capacitive_mode_select;

    always_comb begin
      if (st_q == piezo_pwm_pkg::SEQ_DISCHARGE) begin
        duty = tbl_q[`DISCHARGE_TABLE][idx_q];
      end else begin
        duty = tbl_q[sel_eff][idx_q];
      end
    end

    // On while phase/period < duty/steps; 0.1 us steps round up to whole cycles
    assign on = (11'(phase) * 11'(`DUTY_STEPS)) < (11'(duty) * 11'(`PWM_PERIOD_CYC));

    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        st_q  <= piezo_pwm_pkg::SEQ_IDLE;
        idx_q <= 7'h00;
      end else if (!ctrl_q.capacitive_mode_select) begin
        st_q  <= piezo_pwm_pkg::SEQ_IDLE;
        idx_q <= 7'h00;
      end else if (period_end) begin
        case (st_q)
          piezo_pwm_pkg::SEQ_IDLE: begin
            if (go) begin
              st_q  <= piezo_pwm_pkg::SEQ_CHARGE;
              idx_q <= 7'h00;
            end
          end
          piezo_pwm_pkg::SEQ_CHARGE: begin
            if (!go) begin
              st_q  <= piezo_pwm_pkg::SEQ_DISCHARGE;
              idx_q <= 7'h00;
            end else if (idx_q == `TABLE_LAST) begin
              st_q <= piezo_pwm_pkg::SEQ_HOLD;
            end else begin
              idx_q <= idx_q + 7'h01;
            end
          end
          piezo_pwm_pkg::SEQ_HOLD: begin
            if (!go) begin
              st_q  <= piezo_pwm_pkg::SEQ_DISCHARGE;
              idx_q <= 7'h00;
            end
          end
          piezo_pwm_pkg::SEQ_DISCHARGE: begin
            // Discharge ignores go and completes unless capacitive mode is cleared, which returns to idle mid-table
            if (idx_q == `TABLE_LAST) begin
              st_q  <= piezo_pwm_pkg::SEQ_IDLE;
              idx_q <= 7'h00;
            end else begin
              idx_q <= idx_q + 7'h01;
            end
          end
          default: begin
            st_q <= piezo_pwm_pkg::SEQ_IDLE;
          end
        endcase
      end
    end

    assign charge_sw[ch]        = (st_q == piezo_pwm_pkg::SEQ_CHARGE) && on;
    assign dis_sw[ch]           = (st_q == piezo_pwm_pkg::SEQ_DISCHARGE) && on;
    assign st_code[ch*2 +: 2]   = st_q;
    assign idx_code[ch*7 +: 7]  = idx_q;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      chan_switch_q <= 3'h0;
    end else if (ctrl_q.capacitive_mode_select) begin
      chan_switch_q <= {|dis_sw, charge_sw};
    end else begin
      chan_switch_q <= 3'h0;
    end
  end

  assign chan_switch         = chan_switch_q;
  assign fire_req            = ctrl_q.capacitive_mode_select ? 3'h0 : fire;
  assign sol_cfg             = ctrl_q.capacitive_mode_select ? '0 : sol_q;
  assign ctrl_out            = ctrl_q;
  assign volt_out            = volt_q;
  assign inter_pulse_gap     = gap_q;
  assign calibration_request = cal_q;
  assign fault_flags_clear   = clr_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_fire_at_boundary;
    chan_g[0].go && period_end && (chan_g[0].st_q == piezo_pwm_pkg::SEQ_IDLE);
  endsequence

  sequence s_charge_from_zero;
    (chan_g[0].st_q == piezo_pwm_pkg::SEQ_CHARGE) && (chan_g[0].idx_q == 7'h00);
  endsequence

  sequence s_last_charge_entry;
    (chan_g[0].st_q == piezo_pwm_pkg::SEQ_CHARGE) && (chan_g[0].idx_q == 7'h7F)
      && period_end && chan_g[0].go;
  endsequence

  a_period_length: assert property (period_end |-> ##50 period_end)
    else $error("PWM period is not 50 cycles");
  a_entry_per_period: assert property (((chan_g[0].st_q == piezo_pwm_pkg::SEQ_CHARGE)
      && !period_end && ctrl_q.capacitive_mode_select) |=> $stable(chan_g[0].idx_q))
    else $error("Table entry moved inside a period");
  a_table_end: assert property (s_last_charge_entry |=>
      (chan_g[0].st_q == piezo_pwm_pkg::SEQ_HOLD))
    else $error("Charge did not stop after entry 127");
  a_duty_quantum: assert property (((chan_g[0].st_q == piezo_pwm_pkg::SEQ_CHARGE)
      && (chan_g[0].duty == 5'h01) && (phase == 6'h02)) |-> charge_sw[0] ##1 !charge_sw[0])
    else $error("One duty step is not three cycles on");
  a_discharge_table: assert property ((chan_g[0].st_q == piezo_pwm_pkg::SEQ_DISCHARGE)
      |-> (chan_g[0].duty == tbl_q[3][chan_g[0].idx_q]))
    else $error("Discharge not read from discharge table");
  a_table_pick: assert property ((ctrl_q.charge_table_count <= 2'h1) |-> (sel_eff == 2'h0))
    else $error("Disabled charge table selected");
  a_solenoid_quiet: assert property (!ctrl_q.capacitive_mode_select |=> (chan_switch == 3'h0))
    else $error("Piezo switch active in solenoid mode");
  a_discharge_path: assert property ((ctrl_q.capacitive_mode_select && dis_sw[0])
      |=> chan_switch[2] && !chan_switch[0])
    else $error("Discharge not on channel 3 switch");
  a_solenoid_ignored: assert property (ctrl_q.capacitive_mode_select
      |-> (fire_req == 3'h0) && (sol_cfg == '0))
    else $error("Solenoid settings leak in piezo mode");
  a_fire_gating: assert property (fire[0]
      |-> ctrl_q.whole_unit_on && ctrl_q.injection_gate && ctrl_q.first_channel_fuel_gate)
    else $error("Channel 1 fired without its gates");
  a_single_pulse_trigger_load: assert property (shot_load |=> (single_pulse_trigger_q == SINGLE_PULSE_TRIGGER_CYCLES) ##1 req[0])
    else $error("Single pulse not started");
  a_charge_start: assert property (s_fire_at_boundary |=> s_charge_from_zero)
    else $error("Charge did not start at entry 0");
  a_full_duty: assert property (((chan_g[0].st_q == piezo_pwm_pkg::SEQ_CHARGE)
      && (chan_g[0].duty == 5'h14)) |-> charge_sw[0])
    else $error("Full duty entry not fully on");
  a_zero_duty: assert property ((chan_g[0].duty == 5'h00) |-> !charge_sw[0] && !dis_sw[0])
    else $error("Zero duty entry switched on");

endmodule

// File: piezo_stack_model.sv
`timescale 1ns/10ps

module piezo_stack_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Host side
  input  wire logic [2:0]  fire_want,
  input  wire logic        tally_clear,
  output logic [2:0]       inject_request,
  // Load side
  input  wire logic [2:0]  chan_switch,
  output logic [15:0]      ch1_on_q,
  output logic [15:0]      ch2_on_q,
  output logic [15:0]      drain_on_q
);
  // ----------------------------------------------------------------
  // Host request, moved just after the edge like a real controller
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      inject_request <= 3'h0;
    end else begin
      inject_request <= fire_want;
    end
  end

  // ----------------------------------------------------------------
  // Stack charge tallies
  // ----------------------------------------------------------------
  // On-cycles stand in for charge: the bench reasons in whole cycles
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ch1_on_q   <= 16'h0;
      ch2_on_q   <= 16'h0;
      drain_on_q <= 16'h0;
    end else if (tally_clear) begin
      ch1_on_q   <= 16'h0;
      ch2_on_q   <= 16'h0;
      drain_on_q <= 16'h0;
    end else begin
      ch1_on_q   <= ch1_on_q + 16'(chan_switch[0]);
      ch2_on_q   <= ch2_on_q + 16'(chan_switch[1]);
      drain_on_q <= drain_on_q + 16'(chan_switch[2]);
    end
  end
endmodule

// File: piezo_profile_pwm_driver_bench.sv
`timescale 1ns/10ps
`include "piezo_pwm_regs.svh"

module piezo_profile_pwm_driver_bench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  typedef struct {
    logic [1:0] sel;
    logic [1:0] cnt;
    logic [1:0] tbl;
  } row_s;

  localparam int       TIME_LIMIT = 90000;
  localparam logic [8:0] SOL_ON   = 9'h03F;
  localparam logic [8:0] PZ_ON    = 9'h13F;
  localparam logic [8:0] PULSE_ON = 9'h14F;
  localparam logic [4:0] DRAIN    = 5'h03;

  logic                 clock;
  logic                 rst;
  logic [7:0]           reg_addr;
  logic [31:0]          reg_wdata;
  logic                 reg_write;
  logic                 reg_read;
  logic [31:0]          reg_rdata;
  logic [2:0]           inject_request;
  logic [2:0]           chan_switch;
  logic [2:0]           fire_req;
  piezo_pwm_pkg::sol_s  sol_cfg;
  piezo_pwm_pkg::ctrl_s ctrl_out;
  piezo_pwm_pkg::volt_s volt_out;
  logic [15:0]          inter_pulse_gap;
  logic                 calibration_request;
  logic                 fault_flags_clear;
  logic [2:0]           fire_want;
  logic                 tally_clear;
  logic [15:0]          ch1_on_q;
  logic [15:0]          ch2_on_q;
  logic [15:0]          drain_on_q;
  logic [31:0]          rd_q;
  int                   fails;
  int                   total_checks;
  int                   cycles;
  int                   exp_on;
  // Table a holds one duty step so the single-step on-time is exercised
  logic [4:0]           duty_tbl [3] = '{5'h01, 5'h09, 5'h1F};
  // Select above count and select 0 both fall back to table a
  row_s                 rows [5] = '{'{2'h1, 2'h1, 2'h0}, '{2'h2, 2'h2, 2'h1},
                                     '{2'h3, 2'h3, 2'h2}, '{2'h3, 2'h2, 2'h0},
                                     '{2'h0, 2'h3, 2'h0}};

  piezo_profile_pwm_driver #(.SINGLE_PULSE_TRIGGER_CYCLES(200)) i_dut (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .inject_request(inject_request), .chan_switch(chan_switch), .fire_req(fire_req),
    .sol_cfg(sol_cfg), .ctrl_out(ctrl_out), .volt_out(volt_out),
    .inter_pulse_gap(inter_pulse_gap), .calibration_request(calibration_request),
    .fault_flags_clear(fault_flags_clear)
  );

  piezo_stack_model i_load (
    .clock(clock), .rst(rst), .fire_want(fire_want), .tally_clear(tally_clear),
    .inject_request(inject_request), .chan_switch(chan_switch),
    .ch1_on_q(ch1_on_q), .ch2_on_q(ch2_on_q), .drain_on_q(drain_on_q)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // On-cycles per period; duty above 20 saturates to full on
  function automatic int on_cycles(input logic [4:0] d);
    int n;
    int s;
    n = 0;
    s = (d > 5'h14) ? 20 : int'(d);
    for (int c = 0; c < `PWM_PERIOD_CYC; c++) begin
      if (c * 20 < s * 50) n++;
    end
    return n;
  endfunction

  function automatic logic [31:0] mk_ctrl(input logic [1:0] sel, input logic [1:0] cnt,
                                          input logic [8:0] low);
    return {19'h0, sel, cnt, low};
  endfunction

  task automatic check_val(input string name, input logic [39:0] exp, input logic [39:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    rd_q = reg_rdata;
  endtask

  task automatic load_tbl(input logic [1:0] t, input logic [4:0] d);
    wr(`REG_TBL_PTR, {23'h0, t, 7'h0});
    repeat (`TABLE_DEPTH) wr(`REG_TBL_DATA, {27'h0, d});
  endtask

  task automatic close_out;
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == TIME_LIMIT) begin
      fails++;
      $display("Error cycle limit expected %0d seen %0d", TIME_LIMIT - 1, cycles);
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1; reg_addr = 8'h00; reg_wdata = 32'h0; reg_write = 1'b0; reg_read = 1'b0;
    fire_want = 3'h0; tally_clear = 1'b0; fails = 0; total_checks = 0; cycles = 0;
    repeat (5) @(posedge clock);
    #1;
    check_val("ctrl_out in reset", 40'h0A00, 40'(ctrl_out));
    check_val("chan_switch in reset", 40'h0, 40'(chan_switch));
    @(posedge clock);
    rst <= 1'b0;
    rd(`REG_CTRL);
    check_val("ctrl read", 40'h0A00, 40'(rd_q));
    rd(8'h3C);
    check_val("unmapped read", 40'h0, 40'(rd_q));
    // Solenoid mode: shaping settings pass, switches stay off
    wr(`REG_CTRL, mk_ctrl(2'h1, 2'h1, SOL_ON));
    wr(`REG_SOL_CURRENT, 32'h0000_1234);
    wr(`REG_SOL_TIMES, 32'h0056_5758);
    wr(`REG_VOLT, 32'hABCD_1234);
    wr(`REG_GAP, 32'h0000_0321);
    fire_want   <= 3'h1;
    tally_clear <= 1'b1;
    @(posedge clock);
    tally_clear <= 1'b0;
    repeat (120) @(posedge clock);
    #1;
    check_val("fire_req solenoid", 40'h1, 40'(fire_req));
    check_val("sol_cfg solenoid", 40'h56_5758_1234, 40'(sol_cfg));
    check_val("switch solenoid", 40'h0, 40'(ch1_on_q + drain_on_q));
    check_val("gap", 40'h0321, 40'(inter_pulse_gap));
    @(posedge clock);
    fire_want <= 3'h0;
    for (int t = 0; t < 3; t++) load_tbl(2'(t), duty_tbl[t]);
    load_tbl(`DISCHARGE_TABLE, DRAIN);
    wr(`REG_TBL_PTR, {23'h0, 2'h2, 7'h0});
    rd(`REG_TBL_DATA);
    check_val("saturated entry", 40'h14, 40'(rd_q));
    wr(`REG_CMD, 32'h3);
    #1;
    check_val("calibrate pulse", 40'h1, 40'(calibration_request));
    check_val("clear pulse", 40'h1, 40'(fault_flags_clear));
    @(posedge clock);
    #1;
    check_val("calibrate end", 40'h0, 40'(calibration_request));
    rd(`REG_CMD);
    check_val("cmd read", 40'h0, 40'(rd_q));
    // Ordinary cases: one full charge and discharge per table choice
    foreach (rows[i]) begin
      wr(`REG_CTRL, mk_ctrl(rows[i].sel, rows[i].cnt, PZ_ON));
      tally_clear <= 1'b1;
      fire_want   <= 3'h7;
      @(posedge clock);
      tally_clear <= 1'b0;
      repeat (6520) @(posedge clock);
      #1;
      exp_on = `TABLE_DEPTH * on_cycles(duty_tbl[rows[i].tbl]);
      check_val("charge on-cycles", 40'(exp_on), 40'(ch1_on_q));
      check_val("drain in charge", 40'h0, 40'(drain_on_q));
      check_val("fire_req piezo", 40'h0, 40'(fire_req));
      check_val("sol_cfg piezo", 40'h0, 40'(sol_cfg));
      check_val("volt_out", 40'hABCD_1234, 40'(volt_out));
      rd(`REG_STATUS);
      check_val("table and state", 40'({rows[i].tbl, 4'hA}), 40'(rd_q[19:14]));
      @(posedge clock);
      fire_want <= 3'h0;
      repeat (6520) @(posedge clock);
      #1;
      check_val("drain on-cycles", 40'(128 * on_cycles(DRAIN)), 40'(drain_on_q));
      check_val("charge after drop", 40'(exp_on), 40'(ch1_on_q));
      check_val("second channel", 40'(exp_on), 40'(ch2_on_q));
    end
    // Short single pulse: drop mid-charge still drains the whole table
    wr(`REG_CTRL, mk_ctrl(2'h1, 2'h1, PULSE_ON));
    tally_clear <= 1'b1;
    @(posedge clock);
    tally_clear <= 1'b0;
    wr(`REG_CMD, 32'h4);
    repeat (6800) @(posedge clock);
    #1;
    check_val("pulse drain", 40'(128 * on_cycles(DRAIN)), 40'(drain_on_q));
    check_val("pulse charged", 40'h1, 40'(ch1_on_q != 16'h0));
    close_out();
  end
endmodule
